/* src/ipu_pkg.sv */
// Constants, register map and state types of the two-level interrupt priority unit
package ipu_pkg;

  // ****************************************************************
  // Program counter and vectors
  // ****************************************************************
  localparam int              PC_W     = 21;
  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;

  // ****************************************************************
  // Register map, byte addresses on the AXI4-Lite bus
  // ****************************************************************
  localparam int               ADDR_W        = 8;
  localparam logic [ADDR_W-1:0] OFF_RST_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MAIN_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAG      = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ENABLE    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRIO      = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h14;

  // Field positions
  localparam int BIT_PRIO_MODE = 7;
  localparam int BIT_GIE_HIGH  = 7;
  localparam int BIT_GIE_LOW   = 6;
  localparam int BIT_SVC_HIGH  = 0;
  localparam int BIT_SVC_LOW   = 1;
  localparam int BIT_PENDING   = 2;

  // Reset values
  localparam logic PRIO_RST = 1'h1;
  localparam logic FLAG_RST = 1'h0;
  localparam logic EN_RST   = 1'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing: cycles from an eligible request to the vector load
  // ****************************************************************
  localparam int         LAT_CYCLES = 3;
  localparam logic [1:0] LAT_LOAD   = 2'(LAT_CYCLES - 2);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} ipu_seq_t;

  typedef struct packed {
    ipu_seq_t          seq;
    logic [1:0]        cnt;
    logic              pm;
    logic              gie_h;
    logic              gie_l;
    logic              svc_h;
    logic              svc_l;
    logic              take;
    logic [PC_W-1:0]   vec;
    logic [PC_W-1:0]   push;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [7:0]        wdata;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ipu_state_t;

  typedef struct packed {
    logic flag;
    logic en;
    logic prio;
  } ipu_cell_t;

endpackage

/* src/ipu_src_cell.sv */
// One interrupt source: event flag, source enable and priority bit
`timescale 1ns/1ns
module ipu_src_cell
  import ipu_pkg::*;
(
  input  wire logic clk,       // Core clock
  input  wire logic rst_n,     // Synchronous reset, active low
  input  wire logic event_in,  // Source event pulse
  input  wire logic wr_flag,   // Software write of the flag bit
  input  wire logic wr_en,     // Software write of the enable bit
  input  wire logic wr_prio,   // Software write of the priority bit
  input  wire logic wdata_bit, // Written value
  output logic      flag,      // Event flag
  output logic      en,        // Source enable
  output logic      prio       // 1 = high level
);

  ipu_cell_t cell_reg;
  ipu_cell_t cell_next;

  always_comb
  begin
    cell_next = cell_reg;
    if (wr_flag)
    begin
      cell_next.flag = wdata_bit;
    end
    // Event beats a software clear in the same cycle
    if (event_in)
    begin
      cell_next.flag = 1'h1; // RQ16
    end
    if (wr_en)
    begin
      cell_next.en = wdata_bit; // RQ3
    end
    if (wr_prio)
    begin
      cell_next.prio = wdata_bit; // RQ3
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cell_reg <= '{flag: FLAG_RST, en: EN_RST, prio: PRIO_RST};
    end
    else
    begin
      cell_reg <= cell_next;
    end
  end

  assign flag = cell_reg.flag;
  assign en   = cell_reg.en;
  assign prio = cell_reg.prio;

endmodule

/* src/ipu_top.sv */
// Two-level interrupt priority unit with AXI4-Lite register access
// Notes on behaviour
// RQ1 - High vector 000008h, low vector 000018h
// RQ2 - High preempts low routine; never reverse
// RQ3 - Each source: flag, enable, priority bit
// RQ4 - Priority mode only when reset-control bit7 set
// RQ5 - Priority mode: bit7 admits high sources
// RQ6 - Priority mode: bit6 admits low sources
// RQ7 - Flag, enable, global enable all set: vector
// RQ8 - Compatibility mode ignores priority bits
// RQ9 - Compatibility mode: bit6 gates peripheral sources
// RQ10 - Compatibility mode: bit7 gates every source
// RQ11 - Compatibility mode vectors to 000008h only
// RQ12 - Acceptance clears the admitting global enable
// RQ13 - Acceptance pushes return address, loads vector
// RQ14 - Return instruction sets the global enable again
// RQ15 - Fixed latency, independent of instruction length
// RQ16 - Flags set regardless of any enable
// RQ17 - Software polls, clears flags before re-enabling
// RQ18 - Simultaneous requests: high first, low waits
`timescale 1ns/1ns
module ipu_top
  import ipu_pkg::*;
#(
  parameter int         NUM_SRC     = 8,
  parameter logic [7:0] PERIPH_MASK = 8'hF0
)
(
  input  wire logic                 MCLK,                      // Core clock
  input  wire logic                 RSTN,                      // Sync reset, low
  input  wire logic [ADDR_W-1:0]    S_AXI_AWADDR,              // Write address
  input  wire logic                 S_AXI_AWVALID,             // Write address valid
  output logic                      S_AXI_AWREADY,             // Write address ready
  input  wire logic [31:0]          S_AXI_WDATA,               // Write data
  input  wire logic [3:0]           S_AXI_WSTRB,               // Write strobes
  input  wire logic                 S_AXI_WVALID,              // Write data valid
  output logic                      S_AXI_WREADY,              // Write data ready
  output logic [1:0]                S_AXI_BRESP,               // Write response
  output logic                      S_AXI_BVALID,              // Write response valid
  input  wire logic                 S_AXI_BREADY,              // Write response ready
  input  wire logic [ADDR_W-1:0]    S_AXI_ARADDR,              // Read address
  input  wire logic                 S_AXI_ARVALID,             // Read address valid
  output logic                      S_AXI_ARREADY,             // Read address ready
  output logic [31:0]               S_AXI_RDATA,               // Read data
  output logic [1:0]                S_AXI_RRESP,               // Read response
  output logic                      S_AXI_RVALID,              // Read data valid
  input  wire logic                 S_AXI_RREADY,              // Read data ready
  input  wire logic [NUM_SRC-1:0]   SRC_EVENT,                 // Source event pulses
  input  wire logic [PC_W-1:0]      CORE_RET_ADDR,             // Return address
  input  wire logic                 RETURN_FROM_SERVICE_INSTR, // Return pulse
  output logic                      VEC_TAKE,                  // Push and load pulse
  output logic [PC_W-1:0]           VEC_ADDR,                  // Vector to load
  output logic [PC_W-1:0]           PUSH_ADDR,                 // Address to push
  output logic                      SERVICE_HIGH,              // In high routine
  output logic                      SERVICE_LOW                // In low routine
);

  // ****************************************************************
  // Source cells
  // ****************************************************************
  ipu_state_t         st_reg;
  ipu_state_t         st_next;
  logic [NUM_SRC-1:0] flag_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] prio_vec;
  logic [NUM_SRC-1:0] act;
  logic [NUM_SRC-1:0] pmask;
  logic               wr_flag;
  logic               wr_en;
  logic               wr_prio;
  logic               wr_rst;
  logic               wr_main;
  logic               wr_err;
  logic               do_wr;
  logic [7:0]         wr_byte;
  logic [ADDR_W-1:0]  wr_addr;
  logic               wr_lane;
  logic               elig_c;
  logic               elig_h;
  logic               elig_l;
  logic               elig_any;
  logic               acc;
  logic               acc_l;

  generate
    for (genvar gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      ipu_src_cell u_cell (
        .clk       (MCLK),
        .rst_n     (RSTN),
        .event_in  (SRC_EVENT[gi]),
        .wr_flag   (wr_flag),
        .wr_en     (wr_en),
        .wr_prio   (wr_prio),
        .wdata_bit (wr_byte[gi]),
        .flag      (flag_vec[gi]),
        .en        (en_vec[gi]),
        .prio      (prio_vec[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Request gating
  // ****************************************************************
  assign act   = flag_vec & en_vec; // RQ7
  assign pmask = PERIPH_MASK[NUM_SRC-1:0];
  // Priority bits are not looked at here
  assign elig_c = !st_reg.pm && st_reg.gie_h &&
                  (|(act & (~pmask | {NUM_SRC{st_reg.gie_l}}))); // RQ8 RQ9 RQ10
  assign elig_h = st_reg.pm && st_reg.gie_h && (|(act & prio_vec)); // RQ4 RQ5
  // A low request never enters a running high routine
  assign elig_l = st_reg.pm && st_reg.gie_l && !st_reg.svc_h &&
                  (|(act & ~prio_vec)); // RQ2 RQ6
  assign elig_any = elig_c || elig_h || elig_l;

  // ****************************************************************
  // Bus ready signals and write path
  // ****************************************************************
  assign S_AXI_AWREADY = !st_reg.aw_got && !st_reg.bvalid;
  assign S_AXI_WREADY  = !st_reg.w_got && !st_reg.bvalid;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign wr_addr = st_reg.aw_got ? st_reg.awaddr : S_AXI_AWADDR;
  assign wr_byte = st_reg.w_got ? st_reg.wdata : S_AXI_WDATA[7:0];
  assign wr_lane = (st_reg.w_got ? st_reg.wlane : S_AXI_WSTRB[0]) && do_wr;
  assign do_wr   = (st_reg.aw_got || (S_AXI_AWVALID && S_AXI_AWREADY)) &&
                   (st_reg.w_got || (S_AXI_WVALID && S_AXI_WREADY)) &&
                   !st_reg.bvalid;

  always_comb
  begin
    wr_rst  = 1'h0;
    wr_main = 1'h0;
    wr_flag = 1'h0;
    wr_en   = 1'h0;
    wr_prio = 1'h0;
    wr_err  = 1'h0;
    if (wr_addr == OFF_RST_CTRL)
    begin
      wr_rst = wr_lane;
    end
    else if (wr_addr == OFF_MAIN_CTRL)
    begin
      wr_main = wr_lane;
    end
    else if (wr_addr == OFF_FLAG)
    begin
      wr_flag = wr_lane;
    end
    else if (wr_addr == OFF_ENABLE)
    begin
      wr_en = wr_lane;
    end
    else if (wr_addr == OFF_PRIO)
    begin
      wr_prio = wr_lane;
    end
    else if (wr_addr != OFF_STATUS)
    begin
      wr_err = 1'h1;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next      = st_reg;
    st_next.take = 1'h0;
    acc          = 1'h0;
    st_next.bvalid = st_reg.bvalid && !S_AXI_BREADY;
    st_next.rvalid = st_reg.rvalid && !S_AXI_RREADY;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      st_next.aw_got = 1'h1;
      st_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      st_next.w_got = 1'h1;
      st_next.wdata = S_AXI_WDATA[7:0];
      st_next.wlane = S_AXI_WSTRB[0];
    end
    if (do_wr)
    begin
      st_next.aw_got = 1'h0;
      st_next.w_got  = 1'h0;
      st_next.bvalid = 1'h1;
      st_next.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (wr_rst)
    begin
      st_next.pm = wr_byte[BIT_PRIO_MODE]; // RQ4
    end
    if (wr_main)
    begin
      st_next.gie_h = wr_byte[BIT_GIE_HIGH];
      st_next.gie_l = wr_byte[BIT_GIE_LOW];
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      st_next.rvalid = 1'h1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = 32'h00000000;
      if (S_AXI_ARADDR == OFF_RST_CTRL)
      begin
        st_next.rdata[BIT_PRIO_MODE] = st_reg.pm;
      end
      else if (S_AXI_ARADDR == OFF_MAIN_CTRL)
      begin
        st_next.rdata[BIT_GIE_HIGH] = st_reg.gie_h;
        st_next.rdata[BIT_GIE_LOW]  = st_reg.gie_l;
      end
      else if (S_AXI_ARADDR == OFF_FLAG)
      begin
        st_next.rdata[NUM_SRC-1:0] = flag_vec; // RQ16
      end
      else if (S_AXI_ARADDR == OFF_ENABLE)
      begin
        st_next.rdata[NUM_SRC-1:0] = en_vec;
      end
      else if (S_AXI_ARADDR == OFF_PRIO)
      begin
        st_next.rdata[NUM_SRC-1:0] = prio_vec;
      end
      else if (S_AXI_ARADDR == OFF_STATUS)
      begin
        st_next.rdata[BIT_SVC_HIGH] = st_reg.svc_h;
        st_next.rdata[BIT_SVC_LOW]  = st_reg.svc_l;
        st_next.rdata[BIT_PENDING]  = st_reg.seq == ST_WAIT;
      end
      else
      begin
        st_next.rresp = RESP_SLVERR;
      end
    end
    // Counted in core cycles, not instructions, so length does not matter
    case (st_reg.seq)
      ST_IDLE:
      begin
        if (elig_any)
        begin
          st_next.seq = ST_WAIT; // RQ15
          st_next.cnt = LAT_LOAD;
        end
      end
      ST_WAIT:
      begin
        if (st_reg.cnt != 2'h0)
        begin
          st_next.cnt = st_reg.cnt - 2'h1;
        end
        else
        begin
          st_next.seq = ST_IDLE;
          // Gates are checked again; a withdrawn request is dropped
          acc = elig_any; // RQ7
        end
      end
      default:
      begin
        st_next.seq = ST_IDLE;
      end
    endcase
    if (RETURN_FROM_SERVICE_INSTR)
    begin
      if (!st_reg.pm || st_reg.svc_h)
      begin
        st_next.gie_h = 1'h1; // RQ14
        st_next.svc_h = 1'h0;
        st_next.svc_l = st_reg.pm ? st_reg.svc_l : 1'h0;
      end
      else
      begin
        st_next.gie_l = 1'h1; // RQ14
        st_next.svc_l = 1'h0;
      end
    end
    // Acceptance comes last so its clear of the enable always holds
    if (acc)
    begin
      st_next.take = 1'h1; // RQ13
      st_next.push = CORE_RET_ADDR; // RQ13
      if (acc_l)
      begin
        st_next.vec   = VEC_LOW; // RQ1
        st_next.gie_l = 1'h0; // RQ12
        st_next.svc_l = 1'h1;
      end
      else
      begin
        st_next.vec   = VEC_HIGH; // RQ1 RQ11
        st_next.gie_h = 1'h0; // RQ12
        st_next.svc_h = 1'h1;
      end
    end
  end

  // High wins a tie; the low request stays pending
  assign acc_l = !elig_h && elig_l; // RQ18

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign S_AXI_BVALID = st_reg.bvalid;
  assign S_AXI_BRESP  = st_reg.bresp;
  assign S_AXI_RVALID = st_reg.rvalid;
  assign S_AXI_RDATA  = st_reg.rdata;
  assign S_AXI_RRESP  = st_reg.rresp;
  assign VEC_TAKE     = st_reg.take;
  assign VEC_ADDR     = st_reg.vec;
  assign PUSH_ADDR    = st_reg.push;
  assign SERVICE_HIGH = st_reg.svc_h;
  assign SERVICE_LOW  = st_reg.svc_l;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  chk_compat_one_vec: assert property ( // RQ11
    VEC_TAKE && !$past(st_reg.pm) |-> VEC_ADDR == VEC_HIGH)
    else $error("compatibility vector not high address");
  chk_compat_gate: assert property (VEC_TAKE && !$past(st_reg.pm) |-> $past(st_reg.gie_h)) // RQ10
    else $error("compatibility take without global enable");
  chk_high_gate: assert property ( // RQ5
    VEC_TAKE && $past(st_reg.pm) && VEC_ADDR == VEC_HIGH |-> $past(st_reg.gie_h))
    else $error("high take without high enable");
  chk_low_gate: assert property ( // RQ6
    VEC_TAKE && VEC_ADDR == VEC_LOW |-> $past(st_reg.gie_l) && $past(st_reg.pm))
    else $error("low take without low enable or mode");
  chk_low_not_in_high: assert property ( // RQ2
    VEC_TAKE && VEC_ADDR == VEC_LOW |-> !$past(st_reg.svc_h))
    else $error("low request entered high routine");
  chk_enable_cleared: assert property ( // RQ12
    VEC_TAKE |-> (VEC_ADDR == VEC_LOW) ? !st_reg.gie_l : !st_reg.gie_h)
    else $error("admitting enable not cleared");
  chk_push_addr: assert property ( // RQ13
    acc |=> VEC_TAKE && PUSH_ADDR == $past(CORE_RET_ADDR) ##1 !VEC_TAKE)
    else $error("push address or pulse wrong");
  chk_fixed_latency: assert property ( // RQ15
    st_reg.seq == ST_IDLE && elig_any ##1 elig_any [*2] |=> VEC_TAKE)
    else $error("vector not taken after three cycles");
  chk_flag_sets: assert property ( // RQ16
    |SRC_EVENT |=> (flag_vec & $past(SRC_EVENT)) == $past(SRC_EVENT))
    else $error("event did not set its flag");
  chk_high_first: assert property ( // RQ18
    acc && elig_h && elig_l |=> VEC_ADDR == VEC_HIGH && st_reg.gie_l)
    else $error("low served before high");
  chk_return_high: assert property ( // RQ14
    RETURN_FROM_SERVICE_INSTR && st_reg.svc_h && !acc |=> st_reg.gie_h && !st_reg.svc_h)
    else $error("return did not restore high enable");
  chk_bus_answer: assert property (do_wr |=> S_AXI_BVALID)
    else $error("write response missing");

  cov_high_preempts_low: cover property (st_reg.svc_l && VEC_TAKE && VEC_ADDR == VEC_HIGH);
  cov_low_take: cover property (VEC_TAKE && VEC_ADDR == VEC_LOW);
  cov_compat_take: cover property (VEC_TAKE && !st_reg.pm);
  cov_withdrawn: cover property (st_reg.seq == ST_WAIT && st_reg.cnt == 2'h0 && !elig_any);
endmodule

/* testbench/ipu_core_model.sv */
// Behavioural core model: program counter, return stack, return instruction
`timescale 1ns/1ns
module ipu_core_model
  import ipu_pkg::*;
(
  input  wire logic            clk,       // Core clock
  input  wire logic            rst_n,     // Sync reset, active low
  input  wire logic            take,      // Push and load pulse
  input  wire logic [PC_W-1:0] vec_addr,  // Vector to load
  input  wire logic [PC_W-1:0] push_addr, // Address to push
  input  wire logic            ret_go,    // Bench asks for a return
  output logic      [PC_W-1:0] ret_addr,  // Current program counter
  output logic                 ret_pulse  // Return instruction executed
);
  logic [PC_W-1:0] stack_reg [0:7];
  logic [2:0]      sp_reg;

  // Counter moves every cycle, so a capture in the wrong cycle shows up
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ret_addr  <= 21'h000100;
      ret_pulse <= 1'b0;
      sp_reg    <= 3'h0;
    end
    else
    begin
      ret_pulse <= ret_go;
      if (take)
      begin
        stack_reg[sp_reg] <= push_addr;
        sp_reg            <= sp_reg + 3'h1;
        ret_addr          <= vec_addr;
      end
      else if (ret_pulse)
      begin
        sp_reg   <= sp_reg - 3'h1;
        ret_addr <= stack_reg[sp_reg - 3'h1];
      end
      else
        ret_addr <= ret_addr + 21'h000001;
    end
  end
endmodule

/* testbench/tb_two_level_interrupt_priority_unit.sv */
// Self-checking bench for the two-level interrupt priority unit
`timescale 1ns/1ns
module tb_two_level_interrupt_priority_unit;
  import ipu_pkg::*;
  logic              mclk, rstn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [7:0]        src_ev;
  logic [PC_W-1:0]   ret_addr, vec_addr, push_addr;
  logic              ret_pulse, ret_go, take, svc_h, svc_l;
  int                num_errors;
  int                num_checks;

  ipu_top DUT (
    .MCLK(mclk), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SRC_EVENT(src_ev), .CORE_RET_ADDR(ret_addr), .RETURN_FROM_SERVICE_INSTR(ret_pulse),
    .VEC_TAKE(take), .VEC_ADDR(vec_addr), .PUSH_ADDR(push_addr),
    .SERVICE_HIGH(svc_h), .SERVICE_LOW(svc_l));

  ipu_core_model core (
    .clk(mclk), .rst_n(rstn), .take(take), .vec_addr(vec_addr), .push_addr(push_addr),
    .ret_go(ret_go), .ret_addr(ret_addr), .ret_pulse(ret_pulse));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    // Ready stays high; a following call would otherwise drop and raise it at once
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic ev(input logic [7:0] m);
    src_ev <= m;
    @(posedge mclk);
    src_ev <= 8'h00;
  endtask

  // n < 0: no take expected; n == 0: take within 12 cycles; n > 0: exact cycle count
  task automatic take_chk(input logic [PC_W-1:0] v, input int n, input logic h, input logic l);
    logic [PC_W-1:0] prev;
    logic            seen;
    int              i;
    prev = ret_addr;
    seen = 1'b0;
    for (i = 1; i <= 12 && !seen; i++)
    begin
      @(posedge mclk);
      if (take === 1'b1)
      begin
        seen = 1'b1;
        if (n > 0)
          chk("latency", n, i);
        chk("vector", {11'h0, v}, {11'h0, vec_addr});
        chk("push", {11'h0, prev}, {11'h0, push_addr});
        chk("service", {30'h0, h, l}, {30'h0, svc_h, svc_l});
      end
      prev = ret_addr;
    end
    chk("taken", {31'h0, n >= 0}, {31'h0, seen});
  endtask

  // Return pulse lands one cycle later; enables are set the cycle after that
  task automatic ret();
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(OFF_RST_CTRL, 32'h0);
    rd(OFF_MAIN_CTRL, 32'h0);
    rd(OFF_FLAG, 32'h0);
    rd(OFF_ENABLE, 32'h0);
    rd(OFF_PRIO, {24'h0, {8{PRIO_RST}}});
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 8'hFF, RESP_SLVERR);
    wr(OFF_STATUS, 8'hFF);
    rd(OFF_STATUS, 32'h0);
  endtask

  task automatic t_poll();
    ev(8'h81);
    take_chk(VEC_HIGH, -1, 1'b0, 1'b0);
    rd(OFF_FLAG, 32'h81);
    wr(OFF_FLAG, 8'h00);
    rd(OFF_FLAG, 32'h0);
  endtask

  task automatic t_compat();
    wr(OFF_PRIO, 8'h00);
    wr(OFF_ENABLE, 8'h11);
    ev(8'h01);
    take_chk(VEC_HIGH, -1, 1'b0, 1'b0);
    wr(OFF_FLAG, 8'h00);
    wr(OFF_MAIN_CTRL, 8'h80);
    ev(8'h10);
    take_chk(VEC_HIGH, -1, 1'b0, 1'b0);
    wr(OFF_FLAG, 8'h00);
    ev(8'h01);
    take_chk(VEC_HIGH, 4, 1'b1, 1'b0);
    rd(OFF_MAIN_CTRL, 32'h0);
    wr(OFF_FLAG, 8'h00);
    ret();
    rd(OFF_MAIN_CTRL, 32'h80);
    rd(OFF_STATUS, 32'h0);
    wr(OFF_MAIN_CTRL, 8'hC0);
    ev(8'h10);
    take_chk(VEC_HIGH, 4, 1'b1, 1'b0);
    wr(OFF_FLAG, 8'h00);
    ret();
    wr(OFF_MAIN_CTRL, 8'h00);
  endtask

  task automatic t_prio();
    wr(OFF_RST_CTRL, 8'h80);
    wr(OFF_PRIO, 8'h01);
    wr(OFF_ENABLE, 8'h03);
    wr(OFF_MAIN_CTRL, 8'h40);
    ev(8'h01);
    take_chk(VEC_HIGH, -1, 1'b0, 1'b0);
    ev(8'h02);
    take_chk(VEC_LOW, 4, 1'b0, 1'b1);
    rd(OFF_MAIN_CTRL, 32'h0);
    wr(OFF_MAIN_CTRL, 8'h80);
    take_chk(VEC_HIGH, 0, 1'b1, 1'b1);
    rd(OFF_MAIN_CTRL, 32'h0);
    wr(OFF_FLAG, 8'h02);
    wr(OFF_MAIN_CTRL, 8'h40);
    take_chk(VEC_LOW, -1, 1'b0, 1'b0);
    wr(OFF_FLAG, 8'h00);
    ret();
    rd(OFF_MAIN_CTRL, 32'hC0);
    rd(OFF_STATUS, 32'h2);
    ret();
    rd(OFF_STATUS, 32'h0);
  endtask

  task automatic t_simul();
    ev(8'h03);
    take_chk(VEC_HIGH, 4, 1'b1, 1'b0);
    rd(OFF_MAIN_CTRL, 32'h40);
    wr(OFF_FLAG, 8'h02);
    ret();
    take_chk(VEC_LOW, 0, 1'b0, 1'b1);
  endtask

  // ****************************************************************
  // Clock, reset, sequence and watchdog
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    rstn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready, ret_go} = 6'h00;
    src_ev = 8'h00;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_poll();
    t_compat();
    t_prio();
    t_simul();
    stop_test();
  end

  // Scenarios need well under a thousand cycles
  initial
  begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
